// >>> design/bscan_pkg.sv
// Constants shared by the boundary-scan test port and its cell chain
package bscan_pkg;
   localparam int          IR_LEN        = 8;
   localparam int          CHAIN_LEN     = 94;
   localparam int          ENABLE_CELL   = 26;
   localparam int          SYNC_STAGES   = 2;
   localparam int          TLR_TMS_COUNT = 5;
   localparam logic [7:0]  OP_BYPASS     = 8'hff;
   localparam logic [7:0]  OP_EXTEST     = 8'h00;
   localparam logic [7:0]  OP_INTEST     = 8'h40;
   localparam logic [5:0]  OP_SAMPLE_LOW = 6'h0b;
   localparam logic [7:0]  IR_CAPTURE    = 8'h01;
   localparam logic [7:0]  IR_RESET      = 8'hff;
   // Ones mark input cells; zeros mark output and three-state enable cells
   localparam logic [93:0] IN_CELL_MASK  = 94'h3caaaa0002aaaaaaa8000ffe;

   typedef enum logic [15:0] {
      ST_RESET      = 16'h0001,
      ST_IDLE       = 16'h0002,
      ST_SEL_DR     = 16'h0004,
      ST_CAPTURE_DR = 16'h0008,
      ST_SHIFT_DR   = 16'h0010,
      ST_EXIT1_DR   = 16'h0020,
      ST_PAUSE_DR   = 16'h0040,
      ST_EXIT2_DR   = 16'h0080,
      ST_UPDATE_DR  = 16'h0100,
      ST_SEL_IR     = 16'h0200,
      ST_CAPTURE_IR = 16'h0400,
      ST_SHIFT_IR   = 16'h0800,
      ST_EXIT1_IR   = 16'h1000,
      ST_PAUSE_IR   = 16'h2000,
      ST_EXIT2_IR   = 16'h4000,
      ST_UPDATE_IR  = 16'h8000
   } tap_state_t;
endpackage

// >>> design/bscan_chain_if.sv
// Signals between the test port controller and the boundary cell chain
`timescale 1ns/1ps
interface bscan_chain_if #(parameter int N = 94);
   logic         capture;
   logic         shift;
   logic         update;
   logic         serial_in;
   logic         serial_out;
   logic         extest;
   logic         intest;
   logic         clear;
   logic [N-1:0] pad_in;
   logic [N-1:0] core_out;
   logic [N-1:0] pad_out;
   logic [N-1:0] core_in;

   modport ctrl (output capture, shift, update, serial_in, extest, intest, clear, pad_in, core_out,
                 input serial_out, pad_out, core_in);
   modport chain (input capture, shift, update, serial_in, extest, intest, clear, pad_in, core_out,
                  output serial_out, pad_out, core_in);
endinterface

// >>> design/boundary_chain.sv
// Boundary cell loop: capture, shift and update stages for every pad
`timescale 1ns/1ps
module boundary_chain
   import bscan_pkg::*;
#(
   parameter int               N       = CHAIN_LEN,
   parameter logic [CHAIN_LEN-1:0] IN_MASK = IN_CELL_MASK
)(
   input  wire logic   CLK,    // System clock
   input  wire logic   RESET,  // Asynchronous reset, active high
   bscan_chain_if.chain bus     // Strobes and pad vectors
);
   logic [N-1:0] shift_reg;
   logic [N-1:0] update_reg;
   logic [N-1:0] captured;

   // Input cells watch the pad, output and enable cells watch the core
   assign captured       = (IN_MASK & bus.pad_in) | (~IN_MASK & bus.core_out);
   assign bus.serial_out = shift_reg[0];
   assign bus.pad_out    = bus.extest ? ((~IN_MASK & update_reg) | (IN_MASK & bus.core_out))
                                      : bus.core_out;
   assign bus.core_in    = bus.intest ? ((IN_MASK & update_reg) | (~IN_MASK & bus.pad_in))
                                      : bus.pad_in;

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         shift_reg  <= '0;
         update_reg <= '0;
      end
      else if (bus.clear)
      begin
         update_reg <= '0;
      end
      else
      begin
         if (bus.capture)
            shift_reg <= captured;
         // cell 0 nearest the serial output
         else if (bus.shift)
            shift_reg <= {bus.serial_in, shift_reg[N-1:1]};
         if (bus.update)
            update_reg <= shift_reg;
      end
   end
endmodule

// >>> design/boundary_scan_test_port.sv
// Boundary-scan test access port: pin sampling, controller, instructions and serial output
//
// Notes on behaviour
// - Active-low test reset clears only the controller, instruction, serial output and cell update stages; pulse or hold low.
// - All test logic is paced by the test clock, apart from the test reset.
// - Serial input carries instructions and data; mode select steers the controller.
// - Serial input and mode select are taken on each test clock rising edge.
// - Serial output changes only on a falling edge of the test clock, or when the test reset clears it.
// - Instruction register is exactly eight bits, with no parity bit.
// - All ones selects bypass; all zeros selects external test without inversion.
// - Code 01000000 selects internal test; low six bits 001011 select sample/preload.
// - Test cells sit between every functional pad and the core.
// - Each three-state output group has its own enable cell.
// - Cell 26 enables every frame-store memory pad.
// - Chain holds cells 0 to 93 in fixed order; stream follows it.
`timescale 1ns/1ps
module boundary_scan_test_port
   import bscan_pkg::*;
#(
   parameter int N = CHAIN_LEN
)(
   input  wire logic         CLK,                    // System clock, 50 MHz
   input  wire logic         RESET,                  // Asynchronous reset, active high
   input  wire logic         TCK,                    // Test clock from the outside controller
   input  wire logic         TMS,                    // Test mode select
   input  wire logic         TDI,                    // Test serial data in
   input  wire logic         TRST_N,                 // Test reset, active low
   output logic              TDO,                    // Test serial data out
   output logic              TDO_OE,                 // Serial output driven while shifting
   input  wire logic [N-1:0] PAD_IN,                 // Levels seen at the pads
   input  wire logic [N-1:0] CORE_OUT,               // Core values and enables towards pads
   output logic      [N-1:0] PAD_OUT,                // Values and enables driven to pads
   output logic      [N-1:0] CORE_IN,                // Values handed to the core
   output logic              FRAME_STORE_PAD_ENABLE, // Enable of all frame-store pads
   output logic      [7:0]   INSTRUCTION             // Active instruction
);
   bscan_chain_if #(.N(N)) chain_bus ();

   logic [SYNC_STAGES-1:0] tck_sync;
   logic [SYNC_STAGES-1:0] tms_sync;
   logic [SYNC_STAGES-1:0] tdi_sync;
   logic [SYNC_STAGES-1:0] trst_sync;
   logic [N-1:0]           pad_meta;
   logic [N-1:0]           pad_sync;
   logic                   tck_last;
   tap_state_t             state;
   tap_state_t             next_state;
   logic [IR_LEN-1:0]      ir_shift;
   logic [IR_LEN-1:0]      ir;
   logic                   bypass_bit;
   logic                   tck_rise;
   logic                   tck_fall;
   logic                   tms;
   logic                   tdi;
   logic                   trst_active;
   logic                   sel_bypass;
   logic                   sel_extest;
   logic                   sel_intest;
   logic                   sel_sample;
   logic                   sel_chain;
   logic                   shift_out;
   logic                   shifting;

   //////////////////////////////////////////////////////////////////////////////
   // Next controller state for a given mode select
   function automatic tap_state_t tap_step(input tap_state_t s, input logic m);
      case (s)
         ST_RESET:      tap_step = m ? ST_RESET     : ST_IDLE;
         ST_IDLE:       tap_step = m ? ST_SEL_DR    : ST_IDLE;
         ST_SEL_DR:     tap_step = m ? ST_SEL_IR    : ST_CAPTURE_DR;
         ST_CAPTURE_DR: tap_step = m ? ST_EXIT1_DR  : ST_SHIFT_DR;
         ST_SHIFT_DR:   tap_step = m ? ST_EXIT1_DR  : ST_SHIFT_DR;
         ST_EXIT1_DR:   tap_step = m ? ST_UPDATE_DR : ST_PAUSE_DR;
         ST_PAUSE_DR:   tap_step = m ? ST_EXIT2_DR  : ST_PAUSE_DR;
         ST_EXIT2_DR:   tap_step = m ? ST_UPDATE_DR : ST_SHIFT_DR;
         ST_UPDATE_DR:  tap_step = m ? ST_SEL_DR    : ST_IDLE;
         ST_SEL_IR:     tap_step = m ? ST_RESET     : ST_CAPTURE_IR;
         ST_CAPTURE_IR: tap_step = m ? ST_EXIT1_IR  : ST_SHIFT_IR;
         ST_SHIFT_IR:   tap_step = m ? ST_EXIT1_IR  : ST_SHIFT_IR;
         ST_EXIT1_IR:   tap_step = m ? ST_UPDATE_IR : ST_PAUSE_IR;
         ST_PAUSE_IR:   tap_step = m ? ST_EXIT2_IR  : ST_PAUSE_IR;
         ST_EXIT2_IR:   tap_step = m ? ST_UPDATE_IR : ST_SHIFT_IR;
         ST_UPDATE_IR:  tap_step = m ? ST_SEL_DR    : ST_IDLE;
         default:       tap_step = ST_RESET;
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for every pin from outside this clock
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         tck_sync  <= '0;
         tms_sync  <= '1;
         tdi_sync  <= '1;
         trst_sync <= '0;
         pad_meta  <= '0;
         pad_sync  <= '0;
         tck_last  <= 1'b0;
      end
      else
      begin
         tck_sync  <= {tck_sync[0], TCK};
         tms_sync  <= {tms_sync[0], TMS};
         tdi_sync  <= {tdi_sync[0], TDI};
         trst_sync <= {trst_sync[0], TRST_N};
         pad_meta  <= PAD_IN;
         pad_sync  <= pad_meta;
         tck_last  <= tck_sync[1];
      end
   end

   // test clock edges pace all test logic
   assign tck_rise    = tck_sync[1] & ~tck_last;
   assign tck_fall    = ~tck_sync[1] & tck_last;
   assign tms         = tms_sync[1];
   assign tdi         = tdi_sync[1];
   assign trst_active = ~trst_sync[1];
   assign next_state  = tap_step(state, tms);

   //////////////////////////////////////////////////////////////////////////////
   // Instruction decode; unknown codes fall back to bypass
   // all zeros and 01000000
   assign sel_extest = (ir == OP_EXTEST);
   assign sel_intest = (ir == OP_INTEST);
   assign sel_sample = (ir[5:0] == OP_SAMPLE_LOW);
   assign sel_chain  = sel_extest | sel_intest | sel_sample;
   assign sel_bypass = ~sel_chain;
   assign shifting   = (state == ST_SHIFT_DR) | (state == ST_SHIFT_IR);
   assign shift_out  = (state == ST_SHIFT_IR) ? ir_shift[0]
                     : (sel_bypass ? bypass_bit : chain_bus.serial_out);

   assign chain_bus.capture   = tck_rise & sel_chain & (state == ST_CAPTURE_DR);
   assign chain_bus.shift     = tck_rise & sel_chain & (state == ST_SHIFT_DR);
   assign chain_bus.update    = tck_fall & (sel_extest | sel_intest | sel_sample) & (state == ST_UPDATE_DR);
   assign chain_bus.serial_in = tdi;
   assign chain_bus.extest    = sel_extest;
   assign chain_bus.intest    = sel_intest;
   assign chain_bus.clear     = trst_active;
   assign chain_bus.pad_in    = pad_sync;
   assign chain_bus.core_out  = CORE_OUT;

   boundary_chain #(.N(N), .IN_MASK(IN_CELL_MASK)) cells (
      .CLK   (CLK),
      .RESET (RESET),
      .bus   (chain_bus)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Controller and instruction path, stepped on test clock rising edges; instruction loads on a falling edge in update
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         state    <= ST_RESET;
         ir_shift <= IR_RESET;
         ir       <= IR_RESET;
      end
      else if (trst_active)
      begin
         state    <= ST_RESET;
         ir_shift <= IR_RESET;
         ir       <= IR_RESET;
      end
      else if (tck_rise)
      begin
         // mode select steers, five highs reach reset
         state <= next_state;
         // instruction falls back on entering reset
         if (next_state == ST_RESET)
            ir <= IR_RESET;
         if (state == ST_CAPTURE_IR)
            ir_shift <= IR_CAPTURE;
         else if (state == ST_SHIFT_IR)
            ir_shift <= {tdi, ir_shift[IR_LEN-1:1]};
      end
      else if (tck_fall && state == ST_UPDATE_IR)
      begin
         ir <= ir_shift;
      end
   end

   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         bypass_bit <= 1'b0;
      else if (tck_rise && state == ST_CAPTURE_DR)
         bypass_bit <= 1'b0;
      else if (tck_rise && state == ST_SHIFT_DR)
         bypass_bit <= tdi;
   end

   //////////////////////////////////////////////////////////////////////////////
   // serial output moves only on falling edges or when test reset clears it
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         TDO    <= 1'b0;
         TDO_OE <= 1'b0;
      end
      else if (trst_active)
      begin
         TDO    <= 1'b0;
         TDO_OE <= 1'b0;
      end
      else if (tck_fall)
      begin
         TDO    <= shifting ? shift_out : 1'b0;
         TDO_OE <= shifting;
      end
   end

   // Registered pad, core and enable outputs
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         PAD_OUT                <= '0;
         CORE_IN                <= '0;
         FRAME_STORE_PAD_ENABLE <= 1'b0;
         INSTRUCTION            <= IR_RESET;
      end
      else
      begin
         PAD_OUT                <= chain_bus.pad_out;
         CORE_IN                <= chain_bus.core_in;
         // enable cell 26 for frame store
         FRAME_STORE_PAD_ENABLE <= chain_bus.pad_out[ENABLE_CELL];
         INSTRUCTION            <= ir;
      end
   end
endmodule

// >>> sim/boundary_scan_test_port_assertions.sv
// Pin-level checks of the boundary-scan test port
`timescale 1ns/1ps
module boundary_scan_test_port_assertions
   import bscan_pkg::*;
#(
   parameter int N = CHAIN_LEN
)(
   input wire logic         CLK,                    // Clock
   input wire logic         RESET,                  // Reset
   input wire logic         TCK,                    // Test clock
   input wire logic         TMS,                    // Mode
   input wire logic         TDI,                    // Data in
   input wire logic         TRST_N,                 // Test reset
   input wire logic         TDO,                    // Data out
   input wire logic         TDO_OE,                 // Out enable
   input wire logic [N-1:0] PAD_IN,                 // Pads
   input wire logic [N-1:0] CORE_OUT,               // Core
   input wire logic [N-1:0] PAD_OUT,                // To pads
   input wire logic [N-1:0] CORE_IN,                // To core
   input wire logic         FRAME_STORE_PAD_ENABLE, // Enable
   input wire logic [7:0]   INSTRUCTION             // Opcode
);
   // Last test clock level and cycles since its fall, saturating
   logic [4:0] age_reg;
   wire  logic [3:0] next_age = (age_reg[4] && !TCK) ? 4'h0 : age_reg[3:0] + {3'h0, age_reg[3:0] != 4'hf};
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         age_reg <= 5'h0f;
      else
         age_reg <= {TCK, next_age};
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   property p_tdo_fall; $changed(TDO) && TRST_N |-> age_reg[3:0] <= 4'h6; endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("serial out moved off a clock fall");
   property p_oe_fall; $rose(TDO_OE) |-> !TCK && age_reg[3:0] <= 4'h6; endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("serial enable rose off a clock fall");
   property p_tdo_quiet; $fell(TDO_OE) |-> ##[0:2] !TDO; endproperty
   a_tdo_quiet: assert property (p_tdo_quiet) else $error("serial out not low after release");
   property p_enable; 1'b1 |-> FRAME_STORE_PAD_ENABLE == PAD_OUT[ENABLE_CELL]; endproperty
   a_enable: assert property (p_enable) else $error("memory enable differs from its cell");
   property p_trst; !TRST_N [*5] |-> INSTRUCTION == IR_RESET && !TDO_OE && !TDO; endproperty
   a_trst: assert property (p_trst) else $error("test reset not obeyed");
   property p_pads; (INSTRUCTION != OP_EXTEST) [*3] |-> PAD_OUT == $past(CORE_OUT); endproperty
   a_pads: assert property (p_pads) else $error("pads do not follow core");
   property p_core; (INSTRUCTION != OP_INTEST) [*5] |-> CORE_IN == $past(PAD_IN, 3); endproperty
   a_core: assert property (p_core) else $error("core does not follow pads");
   property p_hold;
      (INSTRUCTION == OP_EXTEST) [*3] ##0 age_reg[3:0] == 4'hf |-> $stable(PAD_OUT & ~IN_CELL_MASK);
   endproperty
   a_hold: assert property (p_hold) else $error("pads moved under external test");
   c_extest: cover property (INSTRUCTION == OP_EXTEST);
   c_intest: cover property (INSTRUCTION == OP_INTEST);
   c_shift: cover property ($rose(TDO_OE));
endmodule
bind boundary_scan_test_port boundary_scan_test_port_assertions #(.N(N)) chk (.CLK(CLK), .RESET(RESET),
   .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST_N(TRST_N), .TDO(TDO), .TDO_OE(TDO_OE), .PAD_IN(PAD_IN),
   .CORE_OUT(CORE_OUT), .PAD_OUT(PAD_OUT), .CORE_IN(CORE_IN),
   .FRAME_STORE_PAD_ENABLE(FRAME_STORE_PAD_ENABLE), .INSTRUCTION(INSTRUCTION));

// >>> sim/tap_controller_model.sv
// Outside test controller driving the test pins
`timescale 1ns/1ps
module tap_controller_model
(
   input  wire logic CLK,    // Pacing clock
   output logic      TCK,    // Test clock, low between frames
   output logic      TMS,    // Mode select
   output logic      TDI,    // Serial data to the port
   output logic      TRST_N, // Test reset, active low
   input  wire logic TDO     // Serial data from the port
);
   initial
   begin
      TCK = 1'b0;
      TMS = 1'b1;
      TDI = 1'b0;
      TRST_N = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic trst_pulse();
      TRST_N = 1'b0;
      tick(8);
      TRST_N = 1'b1;
      tick(4);
   endtask
   task automatic step(input logic ms, input logic di, output logic so);
      TMS = ms;
      TDI = di;
      tick(5);
      so = TDO;
      TCK = 1'b1;
      tick(3);
      TCK = 1'b0;
   endtask
   task automatic scan(input logic ir, input int n, input logic [93:0] din, output logic [93:0] dout);
      logic b;
      dout = '0;
      step(1'b1, ~TDI, b);
      if (ir)
         step(1'b1, ~TDI, b);
      step(1'b0, ~TDI, b);
      step(1'b0, ~TDI, b);
      for (int i = 0; i < n; i++)
         step(i == n - 1, din[i], dout[i]);
      step(1'b1, ~TDI, b);
      step(1'b0, ~TDI, b);
   endtask
endmodule

// >>> sim/boundary_scan_test_port_bench.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module boundary_scan_test_port_bench;
   import bscan_pkg::*;
   localparam logic [93:0] pat_pad  = 94'h35a5_c3c3_0ff0_9966_a55a_3c96;
   localparam logic [93:0] pat_core = 94'h0c3c_a5a5_6996_f00f_5aa5_c369;
   localparam logic [93:0] pat_load = 94'h2b6d_1e4f_8a73_05c9_d2e1_7b38;
   localparam logic [93:0] pat_flip = pat_load ^ (94'h1 << ENABLE_CELL);
   logic        clk = 1'b0, reset = 1'b1, tck, tms, tdi, trst_n, tdo, tdo_oe, fs_en, b;
   logic [93:0] pad_in = '0, core_out = '0, pad_out, core_in, d;
   logic [7:0]  instr;
   int          failures = 0, n_tests = 0, cycles = 0;
   boundary_scan_test_port uut (.CLK(clk), .RESET(reset), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n),
      .TDO(tdo), .TDO_OE(tdo_oe), .PAD_IN(pad_in), .CORE_OUT(core_out), .PAD_OUT(pad_out), .CORE_IN(core_in),
      .FRAME_STORE_PAD_ENABLE(fs_en), .INSTRUCTION(instr));
   tap_controller_model ctl (.CLK(clk), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n), .TDO(tdo));
   always #10 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         failures++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [93:0] seen, input logic [93:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic t_codes();
      logic [7:0] codes [5] = '{OP_EXTEST, OP_INTEST, {2'b11, OP_SAMPLE_LOW}, {2'b01, OP_SAMPLE_LOW}, OP_BYPASS};
      foreach (codes[i])
      begin
         ctl.scan(1'b1, 16, {78'h0, codes[i], 8'h5a}, d);
         check("ir capture", d[7:0], IR_CAPTURE);
         check("ir through", d[15:8], 8'h5a);
         check("instruction", instr, codes[i]);
      end
      ctl.scan(1'b0, 4, 94'hd, d);
      check("bypass", d, 94'ha);
   endtask
   task automatic t_sample_extest();
      pad_in = pat_pad;
      core_out = pat_core;
      ctl.scan(1'b1, 8, {86'h0, 2'b10, OP_SAMPLE_LOW}, d);
      ctl.scan(1'b0, 94, pat_load, d);
      check("chain capture", d, (pat_pad & IN_CELL_MASK) | (pat_core & ~IN_CELL_MASK));
      check("pads pass", pad_out, pat_core);
      ctl.scan(1'b1, 8, {86'h0, OP_EXTEST}, d);
      ctl.tick(16);
      core_out = ~pat_core;
      ctl.tick(4);
      check("extest pads", pad_out & ~IN_CELL_MASK, pat_load & ~IN_CELL_MASK);
      check("memory enable", fs_en, pat_load[ENABLE_CELL]);
      ctl.scan(1'b0, 94, pat_flip, d);
      check("memory enable", fs_en, pat_flip[ENABLE_CELL]);
      check("chain capture", d, (pat_pad & IN_CELL_MASK) | (~pat_core & ~IN_CELL_MASK));
   endtask
   task automatic t_intest_resets();
      ctl.scan(1'b1, 8, {86'h0, OP_INTEST}, d);
      check("intest core", core_in & IN_CELL_MASK, pat_flip & IN_CELL_MASK);
      check("pads pass", pad_out, ~pat_core);
      repeat (5) ctl.step(1'b1, 1'b0, b);
      check("instruction", instr, IR_RESET);
      ctl.step(1'b0, 1'b0, b);
      ctl.scan(1'b1, 8, {86'h0, OP_EXTEST}, d);
      ctl.trst_pulse();
      check("instruction", instr, IR_RESET);
      check("pads pass", pad_out, ~pat_core);
      check("core pass", core_in, pat_pad);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      #1;
      reset = 1'b0;
      ctl.trst_pulse();
      check("instruction", instr, IR_RESET);
      check("serial enable", tdo_oe, 1'b0);
      ctl.step(1'b0, 1'b0, b);
      t_codes();
      t_sample_extest();
      t_intest_resets();
      report_and_stop();
   end
endmodule
